// *** hw/pci_pkg.sv ***
// Package with frame layout, command codes and table sizes for the interpreter.
package pci_pkg;
  // Frame layout: address, instruction, type, bank, value 3..0, checksum.
  localparam int unsigned FRAME_BYTES  = 9;
  localparam logic [3:0]  IDX_ADDR     = 4'h0;
  localparam logic [3:0]  IDX_INSTR    = 4'h1;
  localparam logic [3:0]  IDX_TYPE     = 4'h2;
  localparam logic [3:0]  IDX_BANK     = 4'h3;
  localparam logic [3:0]  IDX_VAL3     = 4'h4;
  localparam logic [3:0]  IDX_CSUM     = 4'h8;
  // Instruction codes.
  localparam logic [7:0]  OP_MOVE      = 8'h04;
  localparam logic [7:0]  OP_SET_AXIS  = 8'h05;
  localparam logic [7:0]  OP_GET_AXIS  = 8'h06;
  localparam logic [7:0]  OP_SET_GLOB  = 8'h09;
  localparam logic [7:0]  OP_GET_GLOB  = 8'h0A;
  localparam logic [7:0]  OP_STORE     = 8'h0B;
  // Move sub types selecting a stored coordinate or a relative target.
  localparam logic [7:0]  MV_STORED_POINT = 8'h02;
  localparam logic [7:0]  MV_RELATIVE  = 8'h01;
  // Banks.
  localparam logic [7:0]  BANK_MODULE  = 8'h00;
  localparam logic [7:0]  BANK_USER    = 8'h02;
  localparam logic [7:0]  BANK_IRQ     = 8'h03;
  // Axis parameter numbers with fixed meaning.
  localparam logic [7:0]  AP_ACT_POS   = 8'h01;
  localparam logic [7:0]  AP_MAX_SPEED = 8'h04;
  // Module parameter holding the serial address.
  localparam logic [7:0]  GP_SER_ADDR  = 8'h42;
  localparam logic [7:0]  SER_ADDR_RST = 8'h01;
  // Restore word index that closes the restore window.
  localparam logic [7:0]  NV_LAST_INDEX = 8'hFF;
  // Reply status codes.
  localparam logic [7:0]  ST_OK        = 8'h64;
  localparam logic [7:0]  ST_BAD_CSUM  = 8'h01;
  localparam logic [7:0]  ST_BAD_CMD   = 8'h02;
  localparam logic [7:0]  ST_BAD_TYPE  = 8'h03;
  localparam logic [7:0]  ST_BAD_VAL   = 8'h04;
  // Table sizes.
  localparam int unsigned N_PARAM      = 256;
  localparam int unsigned N_POINT      = 21;
  typedef enum logic [2:0] {
    PCI_COLLECT, PCI_CHECK, PCI_EXEC, PCI_REPLY
  } pci_state_e;
endpackage

// *** hw/pci_interp.sv ***
// Command interpreter for nine-byte parameter frames.
`timescale 1ns/10ps
module pci_interp
  import pci_pkg::*;
(
  input  wire logic        clk,            // 200 MHz clock.
  input  wire logic        rst,            // Asynchronous reset, high.
  input  wire logic        rx_valid,       // Received byte strobe.
  input  wire logic [7:0]  rx_byte,        // Received byte.
  input  wire logic        frame_start,    // Restart byte collection.
  input  wire logic        standalone,     // High in standalone mode.
  input  wire logic [31:0] act_pos,        // Actual axis position.
  input  wire logic        restore_req,    // Restore user variables pulse.
  input  wire logic        nv_ready,       // Storage accepts a write.
  input  wire logic        nv_rd_valid,    // Restore word strobe.
  input  wire logic [7:0]  nv_rd_index,    // Restore word index.
  input  wire logic [31:0] nv_rd_data,     // Restore word value.
  output logic             reply_valid,    // Reply pulse.
  output logic [7:0]       reply_status,   // Reply status code.
  output logic [31:0]      reply_value,    // Reply value.
  output logic             move_valid,     // Move request pulse.
  output logic [31:0]      move_target,    // Move target position.
  output logic [31:0]      max_speed,      // Maximum positioning speed.
  output logic [31:0]      accu,           // Accumulator.
  output logic [7:0]       ser_addr,       // Current serial address.
  output logic             nv_wr_valid,    // Persist request, held until nv_ready.
  output logic [7:0]       nv_wr_bank,     // Bank to persist.
  output logic [7:0]       nv_wr_index,    // Parameter index to persist.
  output logic [31:0]      nv_wr_data,     // Value to persist.
  output logic             restore_busy    // Restore window open.
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0] axis_q   [N_PARAM];  // Volatile, lost at power off.
  logic [31:0] mod_q    [N_PARAM];
  logic [31:0] user_q   [N_PARAM];
  logic [31:0] irq_q    [N_PARAM];
  logic [31:0] point_q  [N_POINT];  // Written by point commands elsewhere.

  logic [7:0]  fb_q     [FRAME_BYTES];
  logic [3:0]  cnt_q;
  logic [7:0]  sum_q;
  pci_state_e  st_q;
  logic [31:0] rval_q;
  logic [7:0]  rstat_q;
  logic        rd_ok_q;

  logic [7:0]  f_instr;
  logic [7:0]  f_type;
  logic [7:0]  f_bank;
  logic [31:0] f_val;

  // Frame fields; value arrives most significant byte first.
  assign f_instr = fb_q[IDX_INSTR];
  assign f_type  = fb_q[IDX_TYPE];
  assign f_bank  = fb_q[IDX_BANK];
  assign f_val   = {fb_q[IDX_VAL3], fb_q[IDX_VAL3 + 4'h1],
                    fb_q[IDX_VAL3 + 4'h2], fb_q[IDX_VAL3 + 4'h3]};

  // Bank is legal only for module, user and interrupt groups.
  function automatic logic bank_ok(input logic [7:0] b);
    bank_ok = (b == BANK_MODULE) || (b == BANK_USER) ||
              (b == BANK_IRQ);
  endfunction

  // Global read decode, shared by the get and store paths.
  function automatic logic [31:0] glob_rd(input logic [7:0] b,
                                          input logic [7:0] t,
                                          input logic [31:0] m,
                                          input logic [31:0] u,
                                          input logic [31:0] i);
    case (b)
      BANK_MODULE: glob_rd = m;
      BANK_USER:   glob_rd = u;
      default:     glob_rd = i;
    endcase
  endfunction

  // ************************************************************
  // Byte collection and checksum
  // ************************************************************
  // Bytes arriving while a frame is executed are dropped; the host waits
  // for the reply before sending again.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
    end else if (frame_start) begin
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
    end else if (st_q == PCI_COLLECT && rx_valid) begin
      fb_q[cnt_q] <= rx_byte;
      if (cnt_q != IDX_CSUM) begin
        sum_q <= sum_q + rx_byte;
      end
      cnt_q <= (cnt_q == IDX_CSUM) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= PCI_COLLECT;
    end else begin
      case (st_q)
        PCI_COLLECT: begin
          if (rx_valid && !frame_start && cnt_q == IDX_CSUM) begin
            st_q <= PCI_CHECK;
          end
        end
        PCI_CHECK: begin
          // Frames for another address are silently ignored.
          if (fb_q[IDX_ADDR] != ser_addr) begin
            st_q <= PCI_COLLECT;
          end else begin
            st_q <= PCI_EXEC;
          end
        end
        PCI_EXEC:  st_q <= PCI_REPLY;
        PCI_REPLY: st_q <= PCI_COLLECT;
        default:   st_q <= PCI_COLLECT;
      endcase
    end
  end

  // ************************************************************
  // Execution: tables, status, reply value
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rstat_q <= ST_OK;
      rval_q  <= 32'h0000_0000;
      rd_ok_q <= 1'b0;
    end else if (st_q == PCI_EXEC) begin
      rd_ok_q <= 1'b0;
      rval_q  <= 32'h0000_0000;    // Writes reply with value zero.
      rstat_q <= ST_OK;
      if (fb_q[IDX_CSUM] != sum_q) begin
        rstat_q <= ST_BAD_CSUM;
      end else begin
        case (f_instr)
          OP_MOVE: begin
            if (f_type == MV_STORED_POINT && f_val >= N_POINT) begin
              rstat_q <= ST_BAD_VAL;
            end
          end
          OP_SET_AXIS: begin
            axis_q[f_type] <= f_val;
          end
          OP_GET_AXIS: begin
            // Parameter 1 is live position, not a stored word.
            rval_q  <= (f_type == AP_ACT_POS) ? act_pos
                       : axis_q[f_type];
            rd_ok_q <= 1'b1;
          end
          OP_SET_GLOB: begin
            if (!bank_ok(f_bank)) begin
              rstat_q <= ST_BAD_TYPE;
            end else if (f_bank == BANK_MODULE) begin
              mod_q[f_type] <= f_val;
            end else if (f_bank == BANK_USER) begin
              user_q[f_type] <= f_val;
            end else begin
              irq_q[f_type] <= f_val;
            end
          end
          OP_GET_GLOB: begin
            if (!bank_ok(f_bank)) begin
              rstat_q <= ST_BAD_TYPE;
            end else if (f_bank == BANK_MODULE && f_type == GP_SER_ADDR) begin
              // The live address register answers, so a read before the
              // first write returns the reset address and not stale RAM.
              rval_q  <= {24'h00_0000, ser_addr};
              rd_ok_q <= 1'b1;
            end else begin
              rval_q  <= glob_rd(f_bank, f_type, mod_q[f_type],
                                 user_q[f_type], irq_q[f_type]);
              rd_ok_q <= 1'b1;
            end
          end
          OP_STORE: begin
            if (!bank_ok(f_bank)) begin
              rstat_q <= ST_BAD_TYPE;
            end
          end
          default: rstat_q <= ST_BAD_CMD;
        endcase
      end
    end else if (restore_busy && nv_rd_valid) begin
      // Power-on or requested restore of user variables.
      user_q[nv_rd_index] <= nv_rd_data;
    end
  end

  // ************************************************************
  // Reply and accumulator
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reply_valid  <= 1'b0;
      reply_status <= ST_OK;
      reply_value  <= 32'h0000_0000;
    end else begin
      reply_valid <= (st_q == PCI_REPLY);
      if (st_q == PCI_REPLY) begin
        reply_status <= rstat_q;
        reply_value  <= rval_q;
      end
    end
  end

  // Axis reads load the accumulator only in standalone mode; global reads
  // do in both modes when accepted.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accu <= 32'h0000_0000;
    end else if (st_q == PCI_REPLY && rstat_q == ST_OK && rd_ok_q) begin
      if (f_instr == OP_GET_GLOB || standalone) begin
        accu <= rval_q;
      end
    end
  end

  // ************************************************************
  // Motion, speed and address outputs
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      move_valid  <= 1'b0;
      move_target <= 32'h0000_0000;
    end else begin
      move_valid <= 1'b0;
      if (st_q == PCI_REPLY && rstat_q == ST_OK && f_instr == OP_MOVE) begin
        move_valid <= 1'b1;
        if (f_type == MV_STORED_POINT) begin
          // Point must already be set by the host.
          move_target <= point_q[f_val[4:0]];
        end else if (f_type == MV_RELATIVE) begin
          move_target <= act_pos + f_val;
        end else begin
          move_target <= f_val;
        end
      end
    end
  end

  // Speed and address change only on an accepted write, so both hold
  // defined values from reset instead of mirroring uninitialised RAM.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      max_speed <= 32'h0000_0000;
      ser_addr  <= SER_ADDR_RST;
    end else if (st_q == PCI_REPLY && rstat_q == ST_OK) begin
      if (f_instr == OP_SET_AXIS && f_type == AP_MAX_SPEED) begin
        max_speed <= f_val;
      end
      if (f_instr == OP_SET_GLOB && f_bank == BANK_MODULE &&
          f_type == GP_SER_ADDR) begin
        // Takes effect from the next frame; this one is already answered.
        ser_addr <= f_val[7:0];
      end
    end
  end

  // Stored points are written by point commands outside this block.
  // Slot 0 is cleared at reset so that one point is always defined;
  // the others read unknown until the host sets them.
  always_ff @(posedge clk) begin
    if (rst) begin
      point_q[0] <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Non-volatile write requests
  // ************************************************************
  // A single pending slot; a new command is not taken before reply, so
  // a slow store only delays nothing but the write itself.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_wr_valid <= 1'b0;
      nv_wr_bank  <= BANK_MODULE;
      nv_wr_index <= 8'h00;
      nv_wr_data  <= 32'h0000_0000;
    end else begin
      if (nv_wr_valid && nv_ready) begin
        nv_wr_valid <= 1'b0;
      end
      // A request raised in the cycle that retires the previous one wins;
      // one made while the slot still stalls replaces its contents.
      if (st_q == PCI_REPLY && rstat_q == ST_OK) begin
        if (f_instr == OP_SET_GLOB && f_bank == BANK_MODULE) begin
          nv_wr_valid <= 1'b1;
          nv_wr_bank  <= f_bank;
          nv_wr_index <= f_type;
          nv_wr_data  <= f_val;
        end else if (f_instr == OP_STORE) begin
          nv_wr_valid <= 1'b1;
          nv_wr_bank  <= f_bank;
          nv_wr_index <= f_type;
          nv_wr_data  <= glob_rd(f_bank, f_type, mod_q[f_type],
                                 user_q[f_type], irq_q[f_type]);
        end
      end
    end
  end

  // Restore window opens at reset release and on request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restore_busy <= 1'b1;
    end else if (restore_req) begin
      restore_busy <= 1'b1;
    end else if (nv_rd_valid && nv_rd_index == NV_LAST_INDEX) begin
      restore_busy <= 1'b0;
    end
  end

endmodule // pci_interp

// *** sim/pci_interp_props.sv ***
// Checker with timing and status properties of the command interpreter.
`timescale 1ns/10ps
module pci_interp_props
  import pci_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_byte,
  input wire logic        frame_start,
  input wire logic        standalone,
  input wire logic        nv_ready,
  input wire logic        reply_valid,
  input wire logic [7:0]  reply_status,
  input wire logic [31:0] reply_value,
  input wire logic        move_valid,
  input wire logic [31:0] accu,
  input wire logic [7:0]  ser_addr,
  input wire logic        nv_wr_valid,
  input wire logic [7:0]  nv_wr_index,
  input wire logic [31:0] nv_wr_data
);
  // ********************************
  // Frame tracking
  // ********************************
  logic [3:0] cnt_q;
  logic [7:0] sum_q;
  logic [7:0] instr_q;
  logic       addr_ok_q;
  logic       bank0_q;
  logic       last;
  logic       good;
  assign last = rx_valid && !frame_start && cnt_q == 4'h8;
  assign good = last && addr_ok_q && rx_byte == sum_q;
  // Mirrors the byte count; the host never sends while a reply is due.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
    end else if (frame_start) begin
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
    end else if (rx_valid) begin
      cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
      sum_q <= last ? 8'h00 : sum_q + rx_byte;
    end
  end
  // Header fields are read only once a whole frame is in, so no reset.
  always_ff @(posedge clk) begin
    if (rx_valid && cnt_q == 4'h0) addr_ok_q <= rx_byte == ser_addr;
    if (rx_valid && cnt_q == 4'h1) instr_q <= rx_byte;
    if (rx_valid && cnt_q == 4'h3) bank0_q <= rx_byte == 8'h00;
  end
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_reply_lat;
    last && addr_ok_q |-> ##4 reply_valid;
  endproperty
  a_reply_lat: assert property (p_reply_lat)
    else $error("reply late");
  property p_foreign;
    last && !addr_ok_q |-> ##1 !reply_valid [*4];
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign reply");
  property p_bad_sum;
    last && addr_ok_q && rx_byte != sum_q
      |-> ##4 reply_status == ST_BAD_CSUM;
  endproperty
  a_bad_sum: assert property (p_bad_sum)
    else $error("sum not refused");
  property p_set_ok;
    good && instr_q == OP_SET_AXIS && bank0_q
      |-> ##4 reply_status == ST_OK;
  endproperty
  a_set_ok: assert property (p_set_ok)
    else $error("set status");
  property p_direct;
    good && instr_q == OP_GET_AXIS && !standalone
      |-> ##1 $stable(accu) [*4];
  endproperty
  a_direct: assert property (p_direct)
    else $error("accu touched");
  property p_glob_accu;
    good && instr_q == OP_GET_GLOB
      |-> ##4 (reply_status != ST_OK || accu == reply_value);
  endproperty
  a_glob_accu: assert property (p_glob_accu)
    else $error("accu load");
  property p_move;
    move_valid |-> reply_valid && reply_status == ST_OK;
  endproperty
  a_move: assert property (p_move)
    else $error("move alone");
  property p_nv_hold;
    nv_wr_valid && !nv_ready
      |=> nv_wr_valid && $stable(nv_wr_data) && $stable(nv_wr_index);
  endproperty
  a_nv_hold: assert property (p_nv_hold)
    else $error("store dropped");
  c_stall: cover property (nv_wr_valid && !nv_ready);
  c_bad_sum: cover property (last && addr_ok_q && rx_byte != sum_q);
  c_alone: cover property (good && instr_q == OP_GET_AXIS && standalone);
  c_move: cover property (move_valid);
endmodule // pci_interp_props
bind pci_interp pci_interp_props pci_interp_props_inst (.*);

// *** sim/pci_host_model.sv ***
// Host model that sends nine-byte command frames to the interpreter.
`timescale 1ns/10ps
module pci_host_model (
  input  wire logic clk,         // Bench clock.
  output logic      rx_valid,    // Byte strobe.
  output logic [7:0] rx_byte,    // Frame byte.
  output logic      frame_start  // Restart pulse before each frame.
);
  // ********************************
  // Frame sender
  // ********************************
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    frame_start = 1'b0;
  end
  // A nonzero bad value spoils the checksum on purpose.
  task automatic send(input logic [7:0] a, i, t, b, input logic [31:0] v,
                      input logic [7:0] bad);
    logic [7:0] f [9];
    f = '{a, i, t, b, v[31:24], v[23:16], v[15:8], v[7:0], bad};
    for (int k = 0; k < 8; k++) f[8] += f[k];
    @(posedge clk) #1 frame_start = 1'b1;
    for (int k = 0; k < 9; k++) begin
      @(posedge clk) #1 frame_start = 1'b0;
      rx_valid = 1'b1;
      rx_byte = f[k];
    end
    @(posedge clk) #1 rx_valid = 1'b0;
    rx_byte = ~rx_byte; // Idle line shows no stale byte.
  endtask
endmodule // pci_host_model

// *** sim/tb_pci_interp.sv ***
// Self-checking bench for the command interpreter.
`timescale 1ns/10ps
module tb_pci_interp;
  import pci_pkg::*;
  logic clk = 1'b0, rst = 1'b1, standalone = 1'b0, restore_req = 1'b0;
  logic nv_ready = 1'b1, nv_rd_valid = 1'b0, rx_valid, frame_start, got;
  logic [7:0] rx_byte, nv_rd_index = 8'h00, ser_addr, nv_wr_bank, nv_wr_index;
  logic [31:0] act_pos = 32'h0000_2710, nv_rd_data = 32'h0;
  logic reply_valid, move_valid, nv_wr_valid, restore_busy;
  logic [7:0] reply_status;
  logic [31:0] reply_value, move_target, max_speed, accu, nv_wr_data;
  logic [7:0] banks [3] = '{BANK_MODULE, BANK_USER, BANK_IRQ};
  int err_total = 0, checks = 0, cyc = 0;
  // ********************************
  // Clock, instances and tasks
  // ********************************
  always #2.5 clk = ~clk;
  pci_host_model pci_host_model_inst (.*);
  pci_interp pci_interp_inst (.*);
  // The cycle ceiling stops a hung run long after all tests should end.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // Leaves the bench just after the reply edge, or eight cycles on.
  task automatic cmd(input logic [7:0] a, i, t, b, input logic [31:0] v,
                     input logic [7:0] bad = 8'h00);
    got = 1'b0;
    pci_host_model_inst.send(a, i, t, b, v, bad);
    for (int n = 0; n < 8 && got !== 1'b1; n++) begin
      @(posedge clk) #1 got = reply_valid;
    end
  endtask
  task automatic restore(input logic [7:0] i, input logic [31:0] d);
    nv_rd_valid = 1'b1;
    nv_rd_index = i;
    nv_rd_data = d;
    @(posedge clk) #1 nv_rd_index = 8'hFF;
    @(posedge clk) #1 nv_rd_valid = 1'b0;
    @(posedge clk) #1 check(restore_busy, 1'b0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ********************************
  // Tests
  // ********************************
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check(reply_status, ST_OK);
    check(restore_busy, 1'b1);
    check(ser_addr, SER_ADDR_RST);
    restore(8'h05, 32'h1234_5678);
    cmd(8'h01, OP_SET_GLOB, GP_SER_ADDR, BANK_MODULE, 32'h1);
    check(reply_status, ST_OK);
    check(nv_wr_valid, 1'b1);
    check(nv_wr_bank, BANK_MODULE);
    check(nv_wr_index, GP_SER_ADDR);
    check(nv_wr_data, 32'h1);
    check(ser_addr, 8'h01);
    cmd(8'h01, OP_SET_GLOB, GP_SER_ADDR, BANK_MODULE, 32'h3);
    check(ser_addr, 8'h03);
    cmd(8'h03, OP_GET_GLOB, GP_SER_ADDR, BANK_MODULE, 32'h0);
    check(got, 1'b1);
    check(reply_value, 32'h3);
    cmd(8'h03, OP_SET_GLOB, GP_SER_ADDR, BANK_MODULE, 32'h1);
    check(ser_addr, 8'h01);
    cmd(8'h01, OP_GET_GLOB, 8'h05, BANK_USER, 32'h0);
    check(reply_value, 32'h1234_5678);
    check(accu, 32'h1234_5678);
    cmd(8'h02, OP_GET_GLOB, 8'h05, BANK_USER, 32'h0);
    check(got, 1'b0);
    cmd(8'h01, OP_SET_AXIS, AP_MAX_SPEED, 8'h00, 32'h9, 8'h01);
    check(reply_status, ST_BAD_CSUM);
    check(max_speed, 32'h0);
    cmd(8'h01, 8'h01, 8'h00, 8'h00, 32'h0);
    check(reply_status, ST_BAD_CMD);
    $display("test address done");
    cmd(8'h01, OP_SET_AXIS, AP_MAX_SPEED, 8'h00, 32'hC800);
    check(reply_status, ST_OK);
    check(nv_wr_valid, 1'b0);
    @(posedge clk) #1 check(max_speed, 32'hC800);
    cmd(8'h01, OP_GET_AXIS, AP_MAX_SPEED, 8'h00, 32'h0);
    check(reply_value, 32'hC800);
    check(accu, 32'h1234_5678);
    standalone = 1'b1;
    cmd(8'h01, OP_GET_AXIS, AP_ACT_POS, 8'h00, 32'h0);
    check(reply_value, act_pos);
    check(accu, act_pos);
    standalone = 1'b0;
    $display("test axis done");
    foreach (banks[k]) begin
      cmd(8'h01, OP_SET_GLOB, 8'h10, banks[k], 32'hA0 + k);
      check(reply_status, ST_OK);
      cmd(8'h01, OP_GET_GLOB, 8'h10, banks[k], 32'h0);
      check(reply_value, 32'hA0 + k);
      check(accu, 32'hA0 + k);
    end
    cmd(8'h01, OP_SET_GLOB, 8'h10, 8'h01, 32'h5);
    check(reply_status, ST_BAD_TYPE);
    cmd(8'h01, OP_SET_GLOB, 8'h2A, BANK_USER, 32'hCAFE);
    nv_ready = 1'b0;
    cmd(8'h01, OP_STORE, 8'h2A, BANK_USER, 32'h0);
    check(reply_status, ST_OK);
    repeat (3) @(posedge clk);
    #1 check(nv_wr_valid, 1'b1);
    check({nv_wr_bank, nv_wr_index}, {BANK_USER, 8'h2A});
    check(nv_wr_data, 32'hCAFE);
    nv_ready = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(nv_wr_valid, 1'b0);
    $display("test global done");
    cmd(8'h01, OP_MOVE, 8'h00, 8'h00, 32'h0001_5F90);
    check(move_valid, 1'b1);
    check(move_target, 32'h0001_5F90);
    cmd(8'h01, OP_MOVE, MV_RELATIVE, 8'h00, 32'hFFFF_FFFF);
    check(move_target, 32'h0000_270F);
    // Point 0 is cleared by reset; the point commands that set the
    // others are not part of this block, so only point 0 is used.
    cmd(8'h01, OP_MOVE, MV_STORED_POINT, 8'h00, 32'h0);
    check(move_valid, 1'b1);
    check(reply_status, ST_OK);
    check(move_target, 32'h0);
    cmd(8'h01, OP_MOVE, MV_STORED_POINT, 8'h00, 32'h15);
    check(reply_status, ST_BAD_VAL);
    check(move_valid, 1'b0);
    restore_req = 1'b1;
    @(posedge clk) #1 restore_req = 1'b0;
    check(restore_busy, 1'b1);
    restore(8'h07, 32'h55AA);
    cmd(8'h01, OP_GET_GLOB, 8'h07, BANK_USER, 32'h0);
    check(reply_value, 32'h55AA);
    $display("test move and restore done");
    test_done();
  end
endmodule // tb_pci_interp
